// >>> verilog/stpt_pkg.sv
// Package: register map, field positions and carrier types for the supply/temperature monitor and periodic timer
package stpt_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] STPT_IDX_TEMP = 8'h10;
  localparam logic [7:0] STPT_IDX_LV = 8'h11;
  localparam logic [7:0] STPT_IDX_PER = 8'h12;
  localparam logic [7:0] STPT_IDX_RATE_HI = 8'h14;
  localparam logic [7:0] STPT_IDX_RATE_LO = 8'h15;
  // Field positions shared by the control registers
  localparam int STPT_B_FLAG = 0;
  localparam int STPT_B_IRQEN = 1;
  localparam int STPT_B_STATUS = 2;
  localparam int STPT_B_SENSEN = 3;
  localparam int STPT_B_ROUTE = 5;
  localparam int STPT_B_FEAT = 2;
  localparam int STPT_B_OUTEN = 3;
  localparam int STPT_B_WAVE = 4;
  localparam int STPT_B_CLKSEL = 7;
  // Writable masks; other bits read as zero except the flag and status bits
  localparam logic [7:0] STPT_TEMP_WMASK = 8'h2a;
  localparam logic [7:0] STPT_LV_WMASK = 8'h02;
  localparam logic [7:0] STPT_PER_WMASK = 8'h9e;
  // Reset values
  localparam logic [7:0] STPT_RST_BYTE = 8'h00;
  localparam logic [15:0] STPT_RST_RATE = 16'h0000;
  // Tick divider default: one tick is two 20 kHz autonomous periods, 20000 cycles of a 200 MHz clock
  localparam int STPT_ACLK_DIV = 20000;
  // Synchronised analog comparator outputs
  typedef struct packed {
    logic thermal;
    logic undervolt;
  } stpt_cmp_t;
  // Interrupt request bundle
  typedef struct packed {
    logic thermal;
    logic undervolt;
    logic periodic;
  } stpt_irq_t;
endpackage : stpt_pkg

// >>> verilog/stpt_top.sv
// Module: register bank and periodic timer with Wishbone slave
`timescale 1ns/1ps
// Functional notes
// - Route bit selects sensor or bandgap voltage
// - Sensor enable powers sensor and amplifier
// - Thermal status read-only; irq enable, sensor enable and route writable
// - Thermal status follows comparator with hysteresis
// - Thermal flag sets on change, write-one clears
// - Thermal irq equals flag and enable
// - Undervolt status read-only, follows comparator
// - Undervolt flag sets on change, write-one clears
// - Undervolt irq equals flag and enable
// - Clock select writable only while disabled
// - Pulse mode: half-minimum-period pulse each period
// - Square mode: output period twice timer period
// - Pin shows wave only with feature enabled
// - Feature enable starts timer; clear stops it
// - Timeout flag sets each period, write-one clears
// - Periodic irq equals flag and enable
// - Period is 2*(rate+1) ticks of clock
// - Rate writable only while feature disabled
module stpt_top #(
  parameter int ACLK_DIV = stpt_pkg::STPT_ACLK_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator outputs, asynchronous
  input wire logic thermal_cmp_in,
  input wire logic undervolt_cmp_in,
  // Analog controls
  output logic thermal_sensor_enable,
  output logic analog_route_select,
  // Timer pin and interrupts
  output logic periodic_wave_pin,
  output stpt_pkg::stpt_irq_t irq_o
);
  // Comparator synchroniser chains, three stages each
  logic [2:0] th_sync_q;
  logic [2:0] lv_sync_q;
  stpt_pkg::stpt_cmp_t status_q;
  // Control registers
  logic [7:0] temp_q;
  logic [7:0] lv_q;
  logic [7:0] per_q;
  logic [15:0] rate_q;
  logic th_flag_q;
  logic lv_flag_q;
  logic per_flag_q;
  // Timer state
  logic [16:0] tick_cnt_q;
  logic [15:0] aclk_div_q;
  logic aclk_tick;
  logic timeout;
  logic pulse_q;
  logic square_q;
  logic first_q;

  // Bus decode
  logic acc;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack, so a cut cycle never half-writes
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];

  // Write-one-to-clear strobe for a flag at bit 0 of a register
  function automatic logic w1c(input logic w, input logic [7:0] i, input logic [7:0] r, input logic [7:0] d);
    w1c = w && (i == r) && d[stpt_pkg::STPT_B_FLAG];
  endfunction : w1c

  // Synchronisers; only stages two and three are compared
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      th_sync_q <= 3'h0;
      lv_sync_q <= 3'h0;
    end
    else
    begin
      th_sync_q <= {th_sync_q[1:0], thermal_cmp_in};
      lv_sync_q <= {lv_sync_q[1:0], undervolt_cmp_in};
    end
  end

  // Status follows the comparator once stages agree; hysteresis lives in the analog comparator
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      status_q <= '0;
    else
    begin
      if (th_sync_q[2] == th_sync_q[1])
        status_q.thermal <= th_sync_q[2];
      if (lv_sync_q[2] == lv_sync_q[1])
        status_q.undervolt <= lv_sync_q[2];
    end
  end

  // Change flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      th_flag_q <= 1'b0;
      lv_flag_q <= 1'b0;
    end
    else
    begin
      if (th_sync_q[2] == th_sync_q[1] && th_sync_q[2] != status_q.thermal)
        th_flag_q <= 1'b1;
      else if (w1c(wr, idx, stpt_pkg::STPT_IDX_TEMP, wbyte))
        th_flag_q <= 1'b0;
      if (lv_sync_q[2] == lv_sync_q[1] && lv_sync_q[2] != status_q.undervolt)
        lv_flag_q <= 1'b1;
      else if (w1c(wr, idx, stpt_pkg::STPT_IDX_LV, wbyte))
        lv_flag_q <= 1'b0;
    end
  end

  // Thermal and undervolt control bits
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      temp_q <= stpt_pkg::STPT_RST_BYTE;
      lv_q <= stpt_pkg::STPT_RST_BYTE;
    end
    else if (wr && idx == stpt_pkg::STPT_IDX_TEMP)
      temp_q <= wbyte & stpt_pkg::STPT_TEMP_WMASK;
    else if (wr && idx == stpt_pkg::STPT_IDX_LV)
      lv_q <= wbyte & stpt_pkg::STPT_LV_WMASK;
  end

  // Periodic control; clock select frozen while enabled and in the write that enables
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      per_q <= stpt_pkg::STPT_RST_BYTE;
    else if (wr && idx == stpt_pkg::STPT_IDX_PER)
    begin
      per_q <= wbyte & stpt_pkg::STPT_PER_WMASK;
      if (per_q[stpt_pkg::STPT_B_FEAT] || wbyte[stpt_pkg::STPT_B_FEAT])
        per_q[stpt_pkg::STPT_B_CLKSEL] <= per_q[stpt_pkg::STPT_B_CLKSEL];
    end
  end

  // Rate value, locked while the feature runs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rate_q <= stpt_pkg::STPT_RST_RATE;
    else if (wr && !per_q[stpt_pkg::STPT_B_FEAT])
    begin
      if (idx == stpt_pkg::STPT_IDX_RATE_HI)
        rate_q[15:8] <= wbyte;
      else if (idx == stpt_pkg::STPT_IDX_RATE_LO)
        rate_q[7:0] <= wbyte;
    end
  end

  // Autonomous clock tick divider; one tick is two autonomous clock periods
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      aclk_div_q <= 16'h0000;
    else if (!per_q[stpt_pkg::STPT_B_FEAT] || aclk_tick)
      aclk_div_q <= 16'h0000;
    else
      aclk_div_q <= aclk_div_q + 16'h0001;
  end
  assign aclk_tick = (aclk_div_q == 16'(ACLK_DIV - 1));

  // Period counter: 2*(rate+1) ticks; bus clock ticks every cycle
  logic tick;
  logic [16:0] period_last;
  logic [16:0] half_min;
  assign tick = per_q[stpt_pkg::STPT_B_CLKSEL] ? 1'b1 : aclk_tick;
  assign period_last = {rate_q, 1'b1};
  assign timeout = per_q[stpt_pkg::STPT_B_FEAT] && tick && (tick_cnt_q == period_last);
  assign half_min = 17'h00001;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tick_cnt_q <= 17'h00000;
    else if (!per_q[stpt_pkg::STPT_B_FEAT])
      tick_cnt_q <= 17'h00000;
    else if (tick)
      tick_cnt_q <= timeout ? 17'h00000 : tick_cnt_q + 17'h00001;
  end

  // Timeout flag; set wins over write-one clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      per_flag_q <= 1'b0;
    else if (timeout)
      per_flag_q <= 1'b1;
    else if (w1c(wr, idx, stpt_pkg::STPT_IDX_PER, wbyte))
      per_flag_q <= 1'b0;
  end

  // Waveforms: pulse lasts one tick (half of the minimum period of two ticks)
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulse_q <= 1'b0;
      square_q <= 1'b0;
      first_q <= 1'b0;
    end
    else if (!per_q[stpt_pkg::STPT_B_FEAT])
    begin
      pulse_q <= 1'b0;
      square_q <= 1'b0;
      first_q <= 1'b0;
    end
    else
    begin
      first_q <= 1'b1;
      if (timeout)
        pulse_q <= 1'b1;
      else if (tick && tick_cnt_q >= half_min - 17'h00001)
        pulse_q <= 1'b0;
      if (timeout)
        square_q <= ~square_q;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      periodic_wave_pin <= 1'b0;
      irq_o <= '0;
      thermal_sensor_enable <= 1'b0;
      analog_route_select <= 1'b0;
    end
    else
    begin
      periodic_wave_pin <= per_q[stpt_pkg::STPT_B_OUTEN] && per_q[stpt_pkg::STPT_B_FEAT] && first_q &&
        (per_q[stpt_pkg::STPT_B_WAVE] ? square_q : pulse_q);
      irq_o.thermal <= th_flag_q && temp_q[stpt_pkg::STPT_B_IRQEN];
      irq_o.undervolt <= lv_flag_q && lv_q[stpt_pkg::STPT_B_IRQEN];
      irq_o.periodic <= per_flag_q && per_q[stpt_pkg::STPT_B_IRQEN];
      thermal_sensor_enable <= temp_q[stpt_pkg::STPT_B_SENSEN];
      analog_route_select <= temp_q[stpt_pkg::STPT_B_ROUTE];
    end
  end

  // Bus answer: ack one cycle after request, unmapped reads give zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h00000000;
      if (acc && !wb_we_i)
        case (idx)
          stpt_pkg::STPT_IDX_TEMP: wb_dat_o[7:0] <= temp_q | {5'h00, status_q.thermal, 1'b0, th_flag_q};
          stpt_pkg::STPT_IDX_LV: wb_dat_o[7:0] <= lv_q | {5'h00, status_q.undervolt, 1'b0, lv_flag_q};
          stpt_pkg::STPT_IDX_PER: wb_dat_o[7:0] <= per_q | {7'h00, per_flag_q};
          stpt_pkg::STPT_IDX_RATE_HI: wb_dat_o[7:0] <= rate_q[15:8];
          stpt_pkg::STPT_IDX_RATE_LO: wb_dat_o[7:0] <= rate_q[7:0];
          default: wb_dat_o <= 32'h00000000;
        endcase
    end
  end

  // Flag is set in the cycle after each timeout
  AST_PER_FLAG_SET: assert property (@(posedge clk) disable iff (!nrst)
    timeout |=> per_flag_q) else $error("timeout flag not set");
  AST_TH_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    (th_flag_q && temp_q[stpt_pkg::STPT_B_IRQEN]) |=> irq_o.thermal) else $error("thermal irq missing");
  AST_LV_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    !lv_flag_q |=> !irq_o.undervolt) else $error("undervolt irq without flag");
  AST_PER_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    irq_o.periodic |-> $past(per_flag_q)) else $error("periodic irq without flag");
  AST_CLKSEL_LOCK: assert property (@(posedge clk) disable iff (!nrst)
    per_q[stpt_pkg::STPT_B_FEAT] |=> $stable(per_q[stpt_pkg::STPT_B_CLKSEL])) else $error("clksel moved");
  // The enabling write itself may not move the clock select either
  AST_CLKSEL_SAME_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (wr && idx == stpt_pkg::STPT_IDX_PER && wbyte[stpt_pkg::STPT_B_FEAT])
    |=> $stable(per_q[stpt_pkg::STPT_B_CLKSEL])) else $error("clksel moved in enabling write");
  AST_RATE_LOCK: assert property (@(posedge clk) disable iff (!nrst)
    per_q[stpt_pkg::STPT_B_FEAT] |=> $stable(rate_q)) else $error("rate changed while enabled");
  AST_PIN_OFF: assert property (@(posedge clk) disable iff (!nrst)
    !per_q[stpt_pkg::STPT_B_OUTEN] |=> !periodic_wave_pin) else $error("pin active while disabled");
  // No write in the two cycles that could stop the timer before the next timeout
  AST_BUS_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
    (per_q[stpt_pkg::STPT_B_FEAT] && per_q[stpt_pkg::STPT_B_CLKSEL] && timeout && rate_q == 16'h0000 && !wr)
    ##1 !wr |=> timeout) else $error("minimum bus period not two cycles");
  // Status and flag move at the same edge, and a set beats a clear
  AST_TH_CHANGE: assert property (@(posedge clk) disable iff (!nrst)
    $changed(status_q.thermal) |-> th_flag_q) else $error("thermal flag missed change");
  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule : stpt_top

// >>> testbench/stpt_top_tb.sv
// Testbench: register, sensor flag and periodic timer checks over Wishbone
`timescale 1ns/1ps
module stpt_top_tb;
  // Clock, reset and bus drive
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // Comparator inputs and observed outputs
  logic thermal_cmp_in = 1'b0;
  logic undervolt_cmp_in = 1'b0;
  logic thermal_sensor_enable;
  logic analog_route_select;
  logic periodic_wave_pin;
  stpt_pkg::stpt_irq_t irq_o;
  int n_errors = 0;
  int checks_done = 0;
  int hi;
  int lo;
  // 5 ns period
  always #2.5 clk = ~clk;
  // Small tick divider keeps the autonomous-clock runs short
  stpt_top #(.ACLK_DIV(4)) stpt_top_i (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .thermal_cmp_in(thermal_cmp_in), .undervolt_cmp_in(undervolt_cmp_in),
    .thermal_sensor_enable(thermal_sensor_enable), .analog_route_select(analog_route_select),
    .periodic_wave_pin(periodic_wave_pin), .irq_o(irq_o));
  // Verdict and end of run
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // Compare seen against expected
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; held until ack is sampled high
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {22'h0, idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
  endtask : xfer
  // Write shorthand
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    xfer(1'b1, idx, d, v);
  endtask : wr
  // Read, mask and compare
  task rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    xfer(1'b0, idx, 8'h00, v);
    check({24'h0, v & m}, {24'h0, exp});
  endtask : rdc
  // Bounded wait for a pin level
  task wait_pin(input logic v);
    int n;
    n = 0;
    while (periodic_wave_pin !== v)
    begin
      @(posedge clk);
      n++;
      if (n > 400)
      begin
        n_errors++;
        finish_test();
      end
    end
  endtask : wait_pin
  // High and low lengths of one pin cycle, from a rising edge
  task meas;
    wait_pin(1'b0);
    wait_pin(1'b1);
    hi = 0;
    lo = 0;
    while (periodic_wave_pin === 1'b1 && hi < 400)
    begin
      @(posedge clk);
      hi++;
    end
    while (periodic_wave_pin === 1'b0 && lo < 400)
    begin
      @(posedge clk);
      lo++;
    end
  endtask : meas
  // Status/flag/irq walk; the same shape serves both sensors
  task sense(input logic w, input logic [7:0] idx);
    @(posedge clk);
    if (w)
      undervolt_cmp_in <= 1'b1;
    else
      thermal_cmp_in <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(idx, 8'hff, 8'h05);
    wr(idx, 8'h02);
    rdc(idx, 8'hff, 8'h07);
    check(w ? irq_o.undervolt : irq_o.thermal, 1'b1);
    wr(idx, 8'h03);
    rdc(idx, 8'hff, 8'h06);
    check(w ? irq_o.undervolt : irq_o.thermal, 1'b0);
    @(posedge clk);
    if (w)
      undervolt_cmp_in <= 1'b0;
    else
      thermal_cmp_in <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(idx, 8'hff, 8'h03);
    wr(idx, 8'h01);
    rdc(idx, 8'hff, 8'h00);
  endtask : sense
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rdc(stpt_pkg::STPT_IDX_TEMP, 8'hff, 8'h00);
    rdc(stpt_pkg::STPT_IDX_PER, 8'hff, 8'h00);
    wr(8'h13, 8'hff);
    rdc(8'h13, 8'hff, 8'h00);
    wr(stpt_pkg::STPT_IDX_TEMP, 8'hff);
    rdc(stpt_pkg::STPT_IDX_TEMP, 8'hff, 8'h2a);
    check({analog_route_select, thermal_sensor_enable}, 2'b11);
    wr(stpt_pkg::STPT_IDX_TEMP, 8'h08);
    // Register lands at the ack edge, the output flop one edge later
    repeat (2) @(posedge clk);
    check({analog_route_select, thermal_sensor_enable}, 2'b01);
    wr(stpt_pkg::STPT_IDX_TEMP, 8'h00);
    sense(1'b0, stpt_pkg::STPT_IDX_TEMP);
    sense(1'b1, stpt_pkg::STPT_IDX_LV);
    // Bus-clock timer, rate 3: eight clocks a period
    wr(stpt_pkg::STPT_IDX_RATE_LO, 8'h03);
    // Clock select must be set while disabled, before the enabling write
    wr(stpt_pkg::STPT_IDX_PER, 8'h80);
    wr(stpt_pkg::STPT_IDX_PER, 8'h9e);
    rdc(stpt_pkg::STPT_IDX_PER, 8'hfe, 8'h9e);
    meas();
    check(hi, 8);
    check(lo, 8);
    check(irq_o.periodic, 1'b1);
    rdc(stpt_pkg::STPT_IDX_PER, 8'h01, 8'h01);
    wr(stpt_pkg::STPT_IDX_RATE_LO, 8'h07);
    rdc(stpt_pkg::STPT_IDX_RATE_LO, 8'hff, 8'h03);
    wr(stpt_pkg::STPT_IDX_PER, 8'h1e);
    rdc(stpt_pkg::STPT_IDX_PER, 8'hfe, 8'h9e);
    wr(stpt_pkg::STPT_IDX_PER, 8'h8e);
    meas();
    check(hi, 1);
    check(lo, 7);
    wr(stpt_pkg::STPT_IDX_PER, 8'h86);
    hi = 0;
    @(posedge clk);
    repeat (40) @(posedge clk) hi += periodic_wave_pin;
    check(hi, 0);
    // Disabling write keeps the clock select; then the minimum bus-clock period
    wr(stpt_pkg::STPT_IDX_PER, 8'h00);
    rdc(stpt_pkg::STPT_IDX_PER, 8'hfe, 8'h80);
    wr(stpt_pkg::STPT_IDX_RATE_LO, 8'h00);
    wr(stpt_pkg::STPT_IDX_PER, 8'h9e);
    meas();
    check(hi, 2);
    check(lo, 2);
    // Autonomous tick every 4 clocks; the enabling write may not move the clock select
    wr(stpt_pkg::STPT_IDX_PER, 8'h00);
    wr(stpt_pkg::STPT_IDX_PER, 8'h00);
    wr(stpt_pkg::STPT_IDX_RATE_LO, 8'h03);
    wr(stpt_pkg::STPT_IDX_PER, 8'h9e);
    rdc(stpt_pkg::STPT_IDX_PER, 8'hfe, 8'h1e);
    meas();
    check(hi, 32);
    check(lo, 32);
    wr(stpt_pkg::STPT_IDX_PER, 8'h1f);
    rdc(stpt_pkg::STPT_IDX_PER, 8'h01, 8'h00);
    check(irq_o.periodic, 1'b0);
    wr(stpt_pkg::STPT_IDX_PER, 8'h0d);
    meas();
    check(hi, 4);
    check(lo, 28);
    wr(stpt_pkg::STPT_IDX_PER, 8'h09);
    hi = 0;
    @(posedge clk);
    repeat (80) @(posedge clk) hi += periodic_wave_pin;
    check(hi, 0);
    rdc(stpt_pkg::STPT_IDX_PER, 8'h01, 8'h00);
    finish_test();
  end
endmodule : stpt_top_tb
